// ---- dmem_dev.sv ----
// device end: decodes framed bytes and accesses the display memories
//
// Functional notes
// RQ1: config command 010100 sets glyph column source
// RQ2: source codes map columns 1,2 to rom/ram
// RQ3: bank select command 00010 sets bank code
// RQ4: bank codes pick text, glyph, symbol, rom
// RQ5: codes 110/111 ignore writes, read zero
// RQ6: bit7 command loads 7-bit address counter
// RQ7: data read returns byte at counter
// RQ8: text and rom reads give eight bits
// RQ9: glyph and symbol reads zero bits 7-5
// RQ10: counter steps after each data read
// RQ11: data write stores byte at counter; writes landing during a clear are dropped
// RQ12: counter steps after each data write; writes landing during a clear do not step it
// RQ13: host sends upper bits zero to glyph
// RQ14: host disables cursor blink before glyph writes
// RQ15: rom writes discarded, counter still steps
// RQ16: clear command is select 10, byte 00
// RQ17: clear fills text ram with 20h
// RQ18: clear keeps counter and step direction
// RQ19: host clears manually when 20h not blank
// RQ20: direction 1 increments, 0 decrements counter
// RQ21: status bits 5,4 report column source
`timescale 1ns/1ns
`include "dmem_defs.svh"
module dmem_dev
	import dmem_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	dmem_link_if.dev link,
	input wire logic step_direction,
	input wire logic [7:0] rom_byte,
	output logic [6:0] rom_addr,
	output src_t glyph_column_source,
	output logic col1_from_ram,
	output logic col2_from_ram,
	output bank_t bank_code,
	output addr_t addr_counter,
	output logic [7:0] status_byte,
	output logic clear_busy
);
	logic lc_s1_ff;
	logic lc_s2_ff;
	logic lc_s3_ff;
	logic fr_s1_ff;
	logic fr_s2_ff;
	logic rw_s1_ff;
	logic rw_s2_ff;
	logic [1:0] rs_s1_ff;
	logic [1:0] rs_s2_ff;
	logic [7:0] wb_s1_ff;
	logic [7:0] wb_s2_ff;
	logic [1:0] edges_ff;
	logic rise;
	logic done;
	src_t src_ff;
	bank_t bank_ff;
	addr_t addr_ff;
	addr_t nxt_addr;
	logic [7:0] rd_ff;
	logic [7:0] nxt_rd;
	logic [7:0] status_ff;
	logic clr_ff;
	addr_t clr_idx_ff;
	logic [7:0] text_mem [`MEM_DEPTH];
	logic [4:0] glyph_mem [3][`MEM_DEPTH];
	logic [4:0] symbol_mem [`MEM_DEPTH];
	// link pins pass two flops before use; reset parks them at idle so no false edge follows
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			lc_s1_ff <= 1'b0;
			lc_s2_ff <= 1'b0;
			lc_s3_ff <= 1'b0;
			fr_s1_ff <= 1'b0;
			fr_s2_ff <= 1'b0;
			rw_s1_ff <= 1'b0;
			rw_s2_ff <= 1'b0;
			rs_s1_ff <= 2'h0;
			rs_s2_ff <= 2'h0;
			wb_s1_ff <= 8'h00;
			wb_s2_ff <= 8'h00;
		end else begin
			lc_s1_ff <= link.link_clk;
			lc_s2_ff <= lc_s1_ff;
			lc_s3_ff <= lc_s2_ff;
			fr_s1_ff <= link.frame;
			fr_s2_ff <= fr_s1_ff;
			rw_s1_ff <= link.read_not_write;
			rw_s2_ff <= rw_s1_ff;
			rs_s1_ff <= link.register_select;
			rs_s2_ff <= rs_s1_ff;
			wb_s1_ff <= link.write_byte;
			wb_s2_ff <= wb_s1_ff;
		end
	end
	assign rise = lc_s2_ff && !lc_s3_ff;
	// a byte is taken on the second rising link edge of a frame
	// edges_ff parks at two so no later edge can execute the byte twice
	always_ff @(posedge clock) begin
		if (!rst_n || !fr_s2_ff)
			edges_ff <= 2'h0;
		else if (rise && edges_ff != 2'h2)
			edges_ff <= edges_ff + 2'h1;
	end
	assign done = fr_s2_ff && rise && edges_ff == 2'h1;
	// writes landing during a clear are dropped whole, counter step included
	logic cmd_cfg;
	logic cmd_bank;
	logic cmd_addr;
	logic cmd_wr;
	logic cmd_rd;
	logic cmd_clr;
	assign cmd_cfg = done && !rw_s2_ff && rs_s2_ff == `RS_CMD && wb_s2_ff[7:2] == `CFG_OP; // RQ1
	assign cmd_bank = done && !rw_s2_ff && rs_s2_ff == `RS_CMD && wb_s2_ff[7:3] == `BANK_OP; // RQ3
	assign cmd_addr = done && !rw_s2_ff && rs_s2_ff == `RS_CMD && wb_s2_ff[7]; // RQ6
	assign cmd_wr = done && !rw_s2_ff && rs_s2_ff == `RS_DATA && !clr_ff; // RQ11
	assign cmd_rd = done && rw_s2_ff && rs_s2_ff == `RS_DATA; // RQ7
	assign cmd_clr = done && !rw_s2_ff && rs_s2_ff == `RS_CTRL && wb_s2_ff == `CLEAR_OP; // RQ16
	always_ff @(posedge clock) begin
		if (!rst_n)
			src_ff <= `SRC_RESET;
		else if (cmd_cfg)
			src_ff <= wb_s2_ff[1:0]; // RQ1
	end
	always_ff @(posedge clock) begin
		if (!rst_n)
			bank_ff <= `BANK_RESET;
		else if (cmd_bank)
			bank_ff <= wb_s2_ff[2:0]; // RQ3
	end
	// counter steps by one per data access in the chosen direction
	always_comb begin
		nxt_addr = addr_ff;
		if (cmd_addr)
			nxt_addr = wb_s2_ff[6:0]; // RQ6
		else if (cmd_rd || cmd_wr)
			nxt_addr = step_direction ? addr_ff + 7'h01 : addr_ff - 7'h01; // RQ10 RQ12 RQ15 RQ20
	end
	always_ff @(posedge clock) begin
		if (!rst_n)
			addr_ff <= `ADDR_RESET;
		else
			addr_ff <= nxt_addr; // RQ18
	end
	// clear walks every text location one per cycle
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			clr_ff <= 1'b0;
			clr_idx_ff <= 7'h00;
		end else if (cmd_clr) begin
			clr_ff <= 1'b1;
			clr_idx_ff <= 7'h00;
		end else if (clr_ff) begin
			clr_idx_ff <= clr_idx_ff + 7'h01;
			if (clr_idx_ff == 7'(`MEM_DEPTH - 1))
				clr_ff <= 1'b0;
		end
	end
	always_ff @(posedge clock) begin
		if (clr_ff)
			text_mem[clr_idx_ff] <= `BLANK_CODE; // RQ17
		else if (cmd_wr && bank_ff == `BANK_TEXT)
			text_mem[addr_ff] <= wb_s2_ff; // RQ11
	end
	generate
		for (genvar g = 0; g < 3; g++) begin : g_glyph
			always_ff @(posedge clock) begin
				if (cmd_wr && bank_ff == 3'(`BANK_GLYPH0 + g))
					glyph_mem[g][addr_ff] <= wb_s2_ff[4:0]; // RQ11 RQ13
			end
		end
	endgenerate
	always_ff @(posedge clock) begin
		if (cmd_wr && bank_ff == `BANK_SYMBOL)
			symbol_mem[addr_ff] <= wb_s2_ff[4:0];
	end
	// rom and unimplemented banks take no write (RQ15, RQ5)
	assign rom_addr = addr_ff;
	always_comb begin
		case (bank_ff) // RQ4
			`BANK_TEXT: nxt_rd = text_mem[addr_ff]; // RQ8
			`BANK_GLYPH0: nxt_rd = {3'h0, glyph_mem[0][addr_ff]}; // RQ9
			`BANK_GLYPH1: nxt_rd = {3'h0, glyph_mem[1][addr_ff]};
			`BANK_GLYPH2: nxt_rd = {3'h0, glyph_mem[2][addr_ff]};
			`BANK_SYMBOL: nxt_rd = {3'h0, symbol_mem[addr_ff]};
			`BANK_ROM: nxt_rd = rom_byte; // RQ8
			default: nxt_rd = 8'h00; // RQ5
		endcase
	end
	// read data is prepared at the first rising edge, held through the frame
	always_ff @(posedge clock) begin
		if (!rst_n)
			rd_ff <= 8'h00;
		else if (fr_s2_ff && rise && edges_ff == 2'h0 && rw_s2_ff && rs_s2_ff == `RS_DATA)
			rd_ff <= nxt_rd; // RQ7
	end
	assign link.read_byte = rd_ff;
	assign glyph_column_source = src_ff;
	assign col1_from_ram = src_ff[1]; // RQ2
	assign col2_from_ram = src_ff[0]; // RQ2
	assign bank_code = bank_ff;
	assign addr_counter = addr_ff;
	// status is registered so the data output comes from a flop
	always_ff @(posedge clock) begin
		status_ff <= {2'h0, src_ff, step_direction, 3'h0}; // RQ21
	end
	assign status_byte = status_ff;
	assign clear_busy = clr_ff;
endmodule

// ---- dmem_defs.svh ----
// constants for the display memory access command block
`ifndef DMEM_DEFS_SVH
`define DMEM_DEFS_SVH
`define RS_CMD 2'h0
`define RS_DATA 2'h1
`define RS_CTRL 2'h2
`define CFG_OP 6'h14
`define BANK_OP 5'h02
`define CLEAR_OP 8'h00
`define BLANK_CODE 8'h20
`define BANK_TEXT 3'h0
`define BANK_GLYPH0 3'h1
`define BANK_GLYPH1 3'h2
`define BANK_GLYPH2 3'h3
`define BANK_SYMBOL 3'h4
`define BANK_ROM 3'h5
`define SRC_RESET 2'h0
`define BANK_RESET 3'h0
`define ADDR_RESET 7'h00
`define MEM_DEPTH 128
`define LINK_HALF 4
`endif

// ---- dmem_pkg.sv ----
// types shared by both ends of the display memory command link
package dmem_pkg;
	typedef logic [6:0] addr_t;
	typedef logic [2:0] bank_t;
	typedef logic [1:0] src_t;
endpackage

// ---- dmem_link_if.sv ----
// link between the host end and the display memory command end
`timescale 1ns/1ns
interface dmem_link_if;
	logic link_clk;
	logic frame;
	logic read_not_write;
	logic [1:0] register_select;
	logic [7:0] write_byte;
	logic [7:0] read_byte;
	modport dev (input link_clk, input frame, input read_not_write, input register_select,
		input write_byte, output read_byte);
	modport host (output link_clk, output frame, output read_not_write, output register_select,
		output write_byte, input read_byte);
endinterface

// ---- dmem_host.sv ----
// host end: frames one command or data byte per request on the link
`timescale 1ns/1ns
`include "dmem_defs.svh"
module dmem_host
	import dmem_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_read,
	input wire logic [1:0] req_select,
	input wire logic [7:0] req_byte,
	output logic rsp_valid,
	output logic [7:0] rsp_byte,
	dmem_link_if.host link
);
	// link clock from a divider; one frame spans two link periods
	logic [2:0] div_ff;
	logic [1:0] ph_ff;
	logic busy_ff;
	logic clk_ff;
	logic rd_ff;
	logic [1:0] rs_ff;
	logic [7:0] wb_ff;
	logic [7:0] rb_ff;
	logic rv_ff;
	logic tick;
	assign tick = (div_ff == 3'(`LINK_HALF - 1));
	assign req_ready = !busy_ff;
	always_ff @(posedge clock) begin
		if (!rst_n || !busy_ff)
			div_ff <= 3'h0;
		else if (tick)
			div_ff <= 3'h0;
		else
			div_ff <= div_ff + 3'h1;
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			busy_ff <= 1'b0;
			clk_ff <= 1'b0;
			ph_ff <= 2'h0;
			rd_ff <= 1'b0;
			rs_ff <= 2'h0;
			wb_ff <= 8'h00;
		end else if (!busy_ff) begin
			if (req_valid) begin
				busy_ff <= 1'b1;
				ph_ff <= 2'h0;
				rd_ff <= req_read;
				rs_ff <= req_select;
				// byte goes out as given; zero upper bits for glyph and symbol are the requester's job
				wb_ff <= req_byte;
			end
		end else if (tick) begin
			clk_ff <= !clk_ff;
			ph_ff <= ph_ff + 2'h1;
			if (ph_ff == 2'h3)
				busy_ff <= 1'b0;
		end
	end
	// read data is sampled on the last falling link edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rb_ff <= 8'h00;
			rv_ff <= 1'b0;
		end else begin
			rv_ff <= busy_ff && tick && ph_ff == 2'h3 && rd_ff;
			if (busy_ff && tick && ph_ff == 2'h3)
				rb_ff <= link.read_byte;
		end
	end
	assign rsp_valid = rv_ff;
	assign rsp_byte = rb_ff;
	assign link.link_clk = clk_ff;
	assign link.frame = busy_ff;
	assign link.read_not_write = rd_ff;
	assign link.register_select = rs_ff;
	assign link.write_byte = wb_ff;
endmodule

// ---- dmem_sva.sv ----
// link checker for the host and device ends
`timescale 1ns/1ns
module dmem_sva (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic frame,
	input wire logic read_not_write,
	input wire logic [1:0] register_select,
	input wire logic [7:0] write_byte,
	input wire logic [7:0] read_byte
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_frame_len: assert property ($rose(frame) |-> frame[*8] ##1 frame[*8] ##1 !frame)
		else $error("frame length wrong");
	a_fields_hold: assert property (frame && !$rose(frame) |-> $stable(register_select))
		else $error("select moved in frame");
	a_dir_hold: assert property (frame && !$rose(frame) |-> $stable(read_not_write))
		else $error("direction moved in frame");
	a_byte_hold: assert property (frame && !$rose(frame) |-> $stable(write_byte))
		else $error("byte moved in frame");
	a_clk_first: assert property ($rose(frame) |-> ##4 $rose(link_clk))
		else $error("first link edge late");
	a_clk_second: assert property ($rose(frame) |-> ##12 $rose(link_clk))
		else $error("second link edge late");
	a_clk_end: assert property ($fell(frame) |-> $fell(link_clk))
		else $error("link clock not closed");
	a_rdata_hold: assert property (!frame && !$fell(frame) |-> $stable(read_byte))
		else $error("read byte moved idle");
endmodule

// ---- tb.sv ----
// self-checking bench for both link ends
`timescale 1ns/1ns
`include "dmem_defs.svh"
module tb;
	import dmem_pkg::*;
	logic clock, rst_n, req_valid, req_ready, req_read, rsp_valid, dir, busy, c1, c2;
	logic [1:0] req_select;
	logic [7:0] req_byte, rsp_byte, rom_byte, status_byte, got;
	logic [6:0] rom_addr;
	src_t src;
	bank_t bank;
	addr_t addr;
	int mismatches, checks_done;
	dmem_link_if link();
	dmem_host dmem_host_i(.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
		.req_ready(req_ready), .req_read(req_read), .req_select(req_select),
		.req_byte(req_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .link(link));
	dmem_dev dmem_dev_i(.clock(clock), .rst_n(rst_n), .link(link), .step_direction(dir),
		.rom_byte(rom_byte), .rom_addr(rom_addr), .glyph_column_source(src),
		.col1_from_ram(c1), .col2_from_ram(c2), .bank_code(bank), .addr_counter(addr),
		.status_byte(status_byte), .clear_busy(busy));
	dmem_sva dmem_sva_i(.clock(clock), .rst_n(rst_n), .link_clk(link.link_clk),
		.frame(link.frame), .read_not_write(link.read_not_write),
		.register_select(link.register_select), .write_byte(link.write_byte),
		.read_byte(link.read_byte));
	// glyph rom model: data follows the address
	assign rom_byte = {1'b1, rom_addr};
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task cmp(input string name, input logic [7:0] exp, input logic [7:0] seen);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task xfer(input logic rd, input logic [1:0] sel, input logic [7:0] b);
		got = 8'hxx;
		@(negedge clock);
		req_valid = 1'b1;
		req_read = rd;
		req_select = sel;
		req_byte = b;
		@(negedge clock);
		req_valid = 1'b0;
		repeat (24) begin
			@(negedge clock);
			if (rsp_valid === 1'b1) got = rsp_byte;
		end
	endtask
	task wr(input logic [7:0] b);
		xfer(1'b0, `RS_DATA, b);
	endtask
	task rd;
		xfer(1'b1, `RS_DATA, 8'h00);
	endtask
	task ld(input logic [6:0] a);
		xfer(1'b0, `RS_CMD, {1'b1, a});
	endtask
	task bk(input logic [2:0] c);
		xfer(1'b0, `RS_CMD, {`BANK_OP, c});
	endtask
	task s_text;
		bk(`BANK_TEXT);
		ld(7'h05);
		wr(8'ha5);
		wr(8'h3c);
		cmp("addr_wr", 8'h07, {1'b0, addr});
		ld(7'h05);
		rd;
		cmp("text0", 8'ha5, got);
		rd;
		cmp("text1", 8'h3c, got);
		cmp("addr_rd", 8'h07, {1'b0, addr});
	endtask
	task s_down;
		dir = 1'b0;
		ld(7'h00);
		wr(8'h11);
		cmp("addr_dn", 8'h7f, {1'b0, addr});
		ld(7'h00);
		rd;
		cmp("text_dn", 8'h11, got);
		dir = 1'b1;
	endtask
	task s_banks;
		for (int c = 1; c < 5; c++) begin
			bk(3'(c));
			cmp("bank", 8'(c), {5'h00, bank});
			ld(7'h10);
			// upper bits go out zero; cursor and blink live outside this block and stay off
			wr(8'(16 + c));
			ld(7'h10);
			rd;
			cmp("glyph", 8'(16 + c), got);
		end
	endtask
	task s_rom;
		bk(`BANK_ROM);
		ld(7'h03);
		rd;
		cmp("rom", 8'h83, got);
		wr(8'h00);
		cmp("addr_rom", 8'h05, {1'b0, addr});
		for (int c = 6; c < 8; c++) begin
			bk(3'(c));
			wr(8'h55);
			ld(7'h00);
			rd;
			cmp("unimpl", 8'h00, got);
		end
		bk(`BANK_TEXT);
		ld(7'h05);
		rd;
		cmp("unimpl_keep", 8'ha5, got);
	endtask
	task s_cfg;
		for (int c = 0; c < 4; c++) begin
			xfer(1'b0, `RS_CMD, {`CFG_OP, 2'(c)});
			cmp("src", 8'(c), {6'h00, src});
			cmp("cols", 8'(c), {6'h00, c1, c2});
			cmp("status", {2'h0, 2'(c), 4'h8}, status_byte);
		end
	endtask
	task s_clear;
		bk(`BANK_TEXT);
		ld(7'h09);
		wr(8'h66);
		ld(7'h09);
		xfer(1'b0, `RS_CTRL, `CLEAR_OP);
		cmp("clr_busy", 8'h01, {7'h00, busy});
		for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clock);
		cmp("clr_done", 8'h00, {7'h00, busy});
		cmp("addr_clr", 8'h09, {1'b0, addr});
		rd;
		cmp("cleared", `BLANK_CODE, got);
	endtask
	task s_manual;
		// display on/off sits outside this block; the blank fill itself is checked
		bk(`BANK_TEXT);
		ld(7'h33);
		wr(8'h5a);
		ld(7'h00);
		for (int i = 0; i < `MEM_DEPTH; i++) wr(8'ha0);
		cmp("addr_fill", 8'h00, {1'b0, addr});
		ld(7'h33);
		rd;
		cmp("fill_mid", 8'ha0, got);
		ld(7'h7f);
		rd;
		cmp("fill_end", 8'ha0, got);
	endtask
	task s_reset(input logic pulse);
		if (pulse) begin
			@(negedge clock);
			rst_n = 1'b0;
			repeat (5) @(negedge clock);
			rst_n = 1'b1;
		end
		cmp("src_rst", {6'h00, `SRC_RESET}, {6'h00, src});
		cmp("bank_rst", {5'h00, `BANK_RESET}, {5'h00, bank});
		cmp("addr_rst", {1'b0, `ADDR_RESET}, {1'b0, addr});
		cmp("status_rst", {2'h0, `SRC_RESET, 1'b1, 3'h0}, status_byte);
		cmp("clr_rst", 8'h00, {7'h00, busy});
		cmp("ready_rst", 8'h01, {7'h00, req_ready});
	endtask
	task wrap_up;
		$display("mismatches %0d checks %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		wrap_up;
	end
	initial begin
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_read = 1'b0;
		req_select = 2'h0;
		req_byte = 8'h00;
		dir = 1'b1;
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		s_reset(1'b0);
		s_text;
		s_down;
		s_banks;
		s_rom;
		s_cfg;
		s_reset(1'b1);
		s_clear;
		s_manual;
		wrap_up;
	end
endmodule
